// ### bcd_defines.vh
// Constants for the bit and control operation decoder
`ifndef BCD_DEFINES_VH
`define BCD_DEFINES_VH

// Opcode nibbles in word bits 15:12
`define BCD_NIB_BIT_SET     4'h8
`define BCD_NIB_BIT_CLR     4'h9
`define BCD_NIB_BIT_INV     4'h7
`define BCD_NIB_SKIP_ZERO   4'hB
`define BCD_NIB_SKIP_ONE    4'hA
`define BCD_NIB_COND        4'hE
`define BCD_NIB_REL         4'hD
`define BCD_NIB_SECOND      4'hF
`define BCD_NIB_ZERO        4'h0

// Sub-fields of the 1110 group, bits 11:8
`define BCD_COND_PFX        1'h0
`define BCD_CALL_PFX        3'h6
`define BCD_JUMP_HI         4'hF

// Full control words, and the upper-bit prefixes of the two return forms
`define BCD_W_NOP           16'h0000
`define BCD_W_WDT           16'h0004
`define BCD_W_PUSH          16'h0005
`define BCD_W_POP           16'h0006
`define BCD_W_DAW           16'h0007
`define BCD_W_RESET         16'h00FF
`define BCD_W_RETI_HI       15'h0008
`define BCD_W_LITERAL_RETURN_OP_HI      8'h0C

// Bit unit modes
`define BCD_BM_CLR          2'h0
`define BCD_BM_SET          2'h1
`define BCD_BM_INV          2'h2
`define BCD_BM_TEST         2'h3

// Operation classes reported with each executed word
`define BCD_OP_NOP          5'h00
`define BCD_OP_BIT_CLR      5'h01
`define BCD_OP_BIT_SET      5'h02
`define BCD_OP_BIT_INV      5'h03
`define BCD_OP_SKIP_ZERO    5'h04
`define BCD_OP_SKIP_ONE     5'h05
`define BCD_OP_COND_BR      5'h06
`define BCD_OP_REL_JUMP     5'h07
`define BCD_OP_REL_CALL     5'h08
`define BCD_OP_ABS_CALL     5'h09
`define BCD_OP_ABS_JUMP     5'h0A
`define BCD_OP_WDT          5'h0B
`define BCD_OP_DAW          5'h0C
`define BCD_OP_POP          5'h0D
`define BCD_OP_PUSH         5'h0E
`define BCD_OP_RESET        5'h0F
`define BCD_OP_RETI         5'h10
`define BCD_OP_LITERAL_RETURN_OP        5'h11
`define BCD_OP_OTHER        5'h12

// Decoder states
`define BCD_ST_RUN          3'h0
`define BCD_ST_FLUSH        3'h1
`define BCD_ST_WORD2        3'h2
`define BCD_ST_SKIP         3'h3
`define BCD_ST_SKIP2        3'h4

`endif

// ### bcd_bit_unit.v
// Single-bit modify and test on a file register byte
`timescale 1ns/1ps
`include "bcd_defines.vh"

module bcd_bit_unit (
    input  wire [7:0] data_in,    // Current file register value
    input  wire [2:0] bit_sel,    // Selected bit number
    input  wire [1:0] mode,       // Clear, set, invert or test
    output reg  [7:0] data_out,   // Modified byte
    output wire       bit_value   // Selected bit before change
);

    wire [7:0] mask;

    assign mask      = 8'h01 << bit_sel;
    assign bit_value = |(data_in & mask);

    // Only the selected bit moves; a test leaves the byte alone
    always @* begin
        case (mode)
            `BCD_BM_CLR: data_out = data_in & ~mask;
            `BCD_BM_SET: data_out = data_in | mask;
            `BCD_BM_INV: data_out = data_in ^ mask;
            default:     data_out = data_in;
        endcase
    end

endmodule // bcd_bit_unit

// ### bcd_branch_unit.v
// Branch condition check and relative target adder
`timescale 1ns/1ps
`include "bcd_defines.vh"

module bcd_branch_unit #(
    parameter AW = 21                    // Program address width
) (
    input  wire [2:0]    cond,           // Condition field
    input  wire          zero_flag,      // Status zero
    input  wire          carry_flag,     // Status carry
    input  wire          ovf_flag,       // Status overflow
    input  wire          neg_flag,       // Status negative
    input  wire [10:0]   offset,         // Word offset, signed
    input  wire          long_offset,    // 11-bit form, else 8-bit
    input  wire [AW-1:0] pc_next,        // Address of next word
    output reg           taken,          // Condition holds
    output wire [AW-1:0] target          // Relative target address
);

    wire [AW-1:0] sext;

    // Word offset sign-extended then doubled into a byte offset
    assign sext = long_offset ?
        {{(AW-12){offset[10]}}, offset, 1'b0} :
        {{(AW-9){offset[7]}}, offset[7:0], 1'b0};
    assign target = pc_next + sext;

    // Odd codes are the negated sense of the even code below them
    always @* begin
        case (cond[2:1])
            2'h0:    taken = zero_flag  ^ cond[0];
            2'h1:    taken = carry_flag ^ cond[0];
            2'h2:    taken = ovf_flag   ^ cond[0];
            default: taken = neg_flag   ^ cond[0];
        endcase
    end

endmodule // bcd_branch_unit

// ### bcd_decoder.v
// Decoder for bit-oriented and control instruction words
`timescale 1ns/1ps
`include "bcd_defines.vh"

module bcd_decoder #(
    parameter AW = 21                        // Program address width
) (
    input  wire          clk,                // Core clock
    input  wire          sys_rst,            // Synchronous reset
    input  wire          instr_valid,        // Fetched word present
    input  wire [15:0]   instr_word,         // Fetched word
    input  wire [AW-1:0] pc_next,            // Address after this word
    input  wire [7:0]    file_rd_data,       // Addressed file byte
    input  wire          zero_flag,          // Status zero
    input  wire          carry_flag,         // Status carry
    input  wire          ovf_flag,           // Status overflow
    input  wire          neg_flag,           // Status negative
    output reg           op_valid,           // Result outputs valid
    output reg  [4:0]    op_class,           // Decoded class
    output reg           nop_cycle,          // Cycle runs as no-op
    output reg  [7:0]    file_addr,          // File address field
    output reg           access_bank,        // Access bank select
    output reg  [2:0]    bit_sel,            // Bit number field
    output reg           file_wr_en,         // Write back file byte
    output reg  [7:0]    file_wr_data,       // Byte to write back
    output reg           pc_load,            // Load program counter
    output reg  [AW-1:0] pc_target,          // New program address
    output reg           stack_push,         // Push stack_top_entry
    output reg           stack_pop,          // Drop stack_top_entry
    output reg           shadow_save,        // Save shadow copies
    output reg           shadow_restore,     // Restore shadow copies
    output reg           working_register_load,          // Load working_register
    output reg  [7:0]    working_register_literal,       // Literal for it
    output reg           watchdog_restart_op,// Restart watchdog
    output reg           timeout_flag_set,   // Set timeout_flag
    output reg           powerdown_flag_set, // Set powerdown_flag
    output reg           decimal_adjust_op,  // Adjust working_register
    output reg           soft_reset,         // Software device reset
    output reg           global_irq_enable,  // Re-enable global irq
    output reg           peripheral_irq_enable // Re-enable periph irq
);

    // Decoder state and held first word of a two-word op
    reg  [2:0]    state;
    reg  [2:0]    next_state;
    reg  [7:0]    first_lo;
    reg  [7:0]    next_first_lo;
    reg           first_call;
    reg           next_first_call;
    reg           first_shadow;
    reg           next_first_shadow;

    // Next values of the registered outputs
    reg           next_op_valid;
    reg  [4:0]    next_op_class;
    reg           next_nop_cycle;
    reg           next_file_wr_en;
    reg           next_pc_load;
    reg  [AW-1:0] next_pc_target;
    reg           next_stack_push;
    reg           next_stack_pop;
    reg           next_shadow_save;
    reg           next_shadow_restore;
    reg           next_working_register_load;
    reg           next_wdt;
    reg           next_daw;
    reg           next_soft_reset;
    reg           next_irq_en;
    reg  [1:0]    bit_mode;

    // Field views of the incoming word
    wire [3:0]    nib;
    wire [7:0]    bit_result;
    wire          bit_value;
    wire          cond_taken;
    wire [AW-1:0] rel_target;
    wire          is_two_word_first;
    wire [AW-1:0] abs_target;

    assign nib = instr_word[15:12];

    // First words that are followed by a 1111 extension word
    assign is_two_word_first = (nib == `BCD_NIB_COND) &&
        ((instr_word[11:9] == `BCD_CALL_PFX) ||
         (instr_word[11:8] == `BCD_JUMP_HI));

    // Absolute byte address: 20-bit word address, doubled
    assign abs_target = {{(AW-21){1'b0}}, instr_word[11:0],
                         first_lo, 1'b0};

    bcd_bit_unit u_bit (
        .data_in   (file_rd_data),
        .bit_sel   (instr_word[11:9]),
        .mode      (bit_mode),
        .data_out  (bit_result),
        .bit_value (bit_value)
    );

    bcd_branch_unit #(
        .AW (AW)
    ) u_branch (
        .cond        (instr_word[10:8]),
        .zero_flag   (zero_flag),
        .carry_flag  (carry_flag),
        .ovf_flag    (ovf_flag),
        .neg_flag    (neg_flag),
        .offset      (instr_word[10:0]),
        .long_offset (nib == `BCD_NIB_REL),
        .pc_next     (pc_next),
        .taken       (cond_taken),
        .target      (rel_target)
    );

    // Bit unit mode from the opcode nibble
    always @* begin
        case (nib)
            `BCD_NIB_BIT_CLR: bit_mode = `BCD_BM_CLR;
            `BCD_NIB_BIT_SET: bit_mode = `BCD_BM_SET;
            `BCD_NIB_BIT_INV: bit_mode = `BCD_BM_INV;
            default:          bit_mode = `BCD_BM_TEST;
        endcase
    end

    // Main decode: every accepted word gives exactly one cycle
    always @* begin
        next_state          = state;
        next_first_lo       = first_lo;
        next_first_call     = first_call;
        next_first_shadow   = first_shadow;
        next_op_valid       = 1'b0;
        next_op_class       = `BCD_OP_NOP;
        next_nop_cycle      = 1'b0;
        next_file_wr_en     = 1'b0;
        next_pc_load        = 1'b0;
        next_pc_target      = rel_target;
        next_stack_push     = 1'b0;
        next_stack_pop      = 1'b0;
        next_shadow_save    = 1'b0;
        next_shadow_restore = 1'b0;
        next_working_register_load      = 1'b0;
        next_wdt            = 1'b0;
        next_daw            = 1'b0;
        next_soft_reset     = 1'b0;
        next_irq_en         = 1'b0;
        if (instr_valid) begin
            next_op_valid = 1'b1;
            case (state)
                // Word fetched behind a flow change is discarded
                `BCD_ST_FLUSH: begin
                    next_nop_cycle = 1'b1;
                    next_state     = `BCD_ST_RUN;
                end
                // Skipped word; a two-word op costs one more cycle
                `BCD_ST_SKIP: begin
                    next_nop_cycle = 1'b1;
                    next_state = is_two_word_first ?
                                 `BCD_ST_SKIP2 : `BCD_ST_RUN;
                end
                `BCD_ST_SKIP2: begin
                    next_nop_cycle = 1'b1;
                    next_state     = `BCD_ST_RUN;
                end
                // Extension word completes the absolute transfer
                `BCD_ST_WORD2: begin
                    next_state = `BCD_ST_RUN;
                    if (nib == `BCD_NIB_SECOND) begin
                        next_pc_load   = 1'b1;
                        next_pc_target = abs_target;
                        // Word fetched behind the pair is now stale
                        next_state     = `BCD_ST_FLUSH;
                        if (first_call) begin
                            next_op_class    = `BCD_OP_ABS_CALL;
                            next_stack_push  = 1'b1;
                            next_shadow_save = first_shadow;
                        end else begin
                            next_op_class = `BCD_OP_ABS_JUMP;
                        end
                    end else begin
                        // Malformed pair: drop the first word and this one
                        next_op_class  = `BCD_OP_OTHER;
                        next_nop_cycle = 1'b1;
                    end
                end
                default: begin
                    case (nib)
                        `BCD_NIB_BIT_CLR: begin
                            next_op_class   = `BCD_OP_BIT_CLR;
                            next_file_wr_en = 1'b1;
                        end
                        `BCD_NIB_BIT_SET: begin
                            next_op_class   = `BCD_OP_BIT_SET;
                            next_file_wr_en = 1'b1;
                        end
                        `BCD_NIB_BIT_INV: begin
                            next_op_class   = `BCD_OP_BIT_INV;
                            next_file_wr_en = 1'b1;
                        end
                        `BCD_NIB_SKIP_ZERO: begin
                            next_op_class = `BCD_OP_SKIP_ZERO;
                            if (!bit_value)
                                next_state = `BCD_ST_SKIP;
                        end
                        `BCD_NIB_SKIP_ONE: begin
                            next_op_class = `BCD_OP_SKIP_ONE;
                            if (bit_value)
                                next_state = `BCD_ST_SKIP;
                        end
                        `BCD_NIB_REL: begin
                            next_pc_load = 1'b1;
                            next_state   = `BCD_ST_FLUSH;
                            if (instr_word[11]) begin
                                next_op_class   = `BCD_OP_REL_CALL;
                                next_stack_push = 1'b1;
                            end else begin
                                next_op_class = `BCD_OP_REL_JUMP;
                            end
                        end
                        `BCD_NIB_COND: begin
                            if (instr_word[11] == `BCD_COND_PFX) begin
                                next_op_class = `BCD_OP_COND_BR;
                                if (cond_taken) begin
                                    next_pc_load = 1'b1;
                                    next_state   = `BCD_ST_FLUSH;
                                end
                            end else if (is_two_word_first) begin
                                // Hold low target bits for word two
                                next_first_lo     = instr_word[7:0];
                                next_first_call   = ~instr_word[9] |
                                                    ~instr_word[8];
                                next_first_shadow = instr_word[8];
                                next_op_class     = `BCD_OP_NOP;
                                next_state        = `BCD_ST_WORD2;
                            end else begin
                                next_op_class = `BCD_OP_OTHER;
                            end
                        end
                        `BCD_NIB_SECOND: begin
                            next_op_class  = `BCD_OP_NOP;
                            next_nop_cycle = 1'b1;
                        end
                        `BCD_NIB_ZERO: begin
                            if (instr_word == `BCD_W_NOP) begin
                                next_op_class  = `BCD_OP_NOP;
                                next_nop_cycle = 1'b1;
                            end else if (instr_word == `BCD_W_WDT) begin
                                next_op_class = `BCD_OP_WDT;
                                next_wdt      = 1'b1;
                            end else if (instr_word == `BCD_W_DAW) begin
                                next_op_class = `BCD_OP_DAW;
                                next_daw      = 1'b1;
                            end else if (instr_word == `BCD_W_POP) begin
                                next_op_class  = `BCD_OP_POP;
                                next_stack_pop = 1'b1;
                            end else if (instr_word == `BCD_W_PUSH) begin
                                next_op_class   = `BCD_OP_PUSH;
                                next_stack_push = 1'b1;
                            end else if (instr_word == `BCD_W_RESET) begin
                                next_op_class   = `BCD_OP_RESET;
                                next_soft_reset = 1'b1;
                                next_state      = `BCD_ST_RUN;
                            end else if (instr_word[15:1] ==
                                         `BCD_W_RETI_HI) begin
                                next_op_class       = `BCD_OP_RETI;
                                next_stack_pop      = 1'b1;
                                next_pc_load        = 1'b1;
                                next_irq_en         = 1'b1;
                                next_shadow_restore = instr_word[0];
                                next_state          = `BCD_ST_FLUSH;
                            end else if (instr_word[15:8] ==
                                         `BCD_W_LITERAL_RETURN_OP_HI) begin
                                next_op_class  = `BCD_OP_LITERAL_RETURN_OP;
                                next_stack_pop = 1'b1;
                                next_pc_load   = 1'b1;
                                next_working_register_load = 1'b1;
                                next_state     = `BCD_ST_FLUSH;
                            end else begin
                                next_op_class = `BCD_OP_OTHER;
                            end
                        end
                        default: next_op_class = `BCD_OP_OTHER;
                    endcase
                end
            endcase
        end
    end

    // Registered outputs; field copies follow every accepted word.
    // Returns load the pc from the stack, so the target is unused there.
    always @(posedge clk) begin
        if (sys_rst) begin
            state                 <= `BCD_ST_RUN;
            first_lo              <= 8'h00;
            first_call            <= 1'b0;
            first_shadow          <= 1'b0;
            op_valid              <= 1'b0;
            op_class              <= `BCD_OP_NOP;
            nop_cycle             <= 1'b0;
            file_addr             <= 8'h00;
            access_bank           <= 1'b0;
            bit_sel               <= 3'h0;
            file_wr_en            <= 1'b0;
            file_wr_data          <= 8'h00;
            pc_load               <= 1'b0;
            pc_target             <= {AW{1'b0}};
            stack_push            <= 1'b0;
            stack_pop             <= 1'b0;
            shadow_save           <= 1'b0;
            shadow_restore        <= 1'b0;
            working_register_load             <= 1'b0;
            working_register_literal          <= 8'h00;
            watchdog_restart_op   <= 1'b0;
            timeout_flag_set      <= 1'b0;
            powerdown_flag_set    <= 1'b0;
            decimal_adjust_op     <= 1'b0;
            soft_reset            <= 1'b0;
            global_irq_enable     <= 1'b0;
            peripheral_irq_enable <= 1'b0;
        end else begin
            state                 <= next_state;
            first_lo              <= next_first_lo;
            first_call            <= next_first_call;
            first_shadow          <= next_first_shadow;
            op_valid              <= next_op_valid;
            op_class              <= next_op_class;
            nop_cycle             <= next_nop_cycle;
            file_wr_en            <= next_file_wr_en;
            pc_load               <= next_pc_load;
            stack_push            <= next_stack_push;
            stack_pop             <= next_stack_pop;
            shadow_save           <= next_shadow_save;
            shadow_restore        <= next_shadow_restore;
            working_register_load             <= next_working_register_load;
            watchdog_restart_op   <= next_wdt;
            timeout_flag_set      <= next_wdt;
            powerdown_flag_set    <= next_wdt;
            decimal_adjust_op     <= next_daw;
            soft_reset            <= next_soft_reset;
            global_irq_enable     <= next_irq_en;
            peripheral_irq_enable <= next_irq_en;
            if (instr_valid) begin
                file_addr    <= instr_word[7:0];
                access_bank  <= instr_word[8];
                bit_sel      <= instr_word[11:9];
                file_wr_data <= bit_result;
                working_register_literal <= instr_word[7:0];
                pc_target    <= next_pc_target;
            end
        end
    end

endmodule // bcd_decoder

// ### bcd_prog_mem.sv
// Program memory model that feeds instruction words to the decoder
`timescale 1ns/1ps
module bcd_prog_mem (
    input  wire        clk,         // Core clock
    input  wire        sys_rst,     // Synchronous reset
    input  wire        stall,       // Withhold the next word
    output reg         instr_valid, // Word present
    output reg  [15:0] instr_word,  // Word
    output reg  [20:0] pc_next      // Byte address after word
);
    reg [15:0] mem [0:4095];
    integer    pc = 0;
    initial {instr_valid, instr_word, pc_next} = 0;
    // Idle cycles show the inverse so a stale word never looks fresh
    always @(posedge clk) begin
        if (instr_valid)
            pc = pc + 1;
        instr_valid <= #1 !sys_rst && !stall;
        instr_word  <= #1 (!sys_rst && !stall) ? mem[pc] : ~instr_word;
        pc_next     <= #1 2 * pc + 2;
    end
endmodule // bcd_prog_mem

// ### bcd_decoder_sva.sv
// Assertion checker for the control word decoder
`timescale 1ns/1ps
module bcd_decoder_chk (
    input wire        clk,                 // Core clock
    input wire        sys_rst,             // Reset
    input wire        instr_valid,         // Word offered
    input wire [15:0] instr_word,          // Word
    input wire        op_valid,            // Result valid
    input wire        nop_cycle,           // Dead cycle
    input wire        pc_load,             // Redirect
    input wire        file_wr_en,          // File write
    input wire        stack_push,          // Push
    input wire        watchdog_restart_op, // Watchdog
    input wire        decimal_adjust_op,   // Adjust
    input wire        soft_reset           // Device reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A stale prefetched word must not run after a redirect
    sequence s_redir; pc_load ##1 op_valid; endsequence
    property p_flush; s_redir |-> nop_cycle; endproperty
    a_flush: assert property (p_flush) else $error("stale word ran");
    property p_zero; instr_valid && instr_word == 16'h0000
        |=> op_valid && nop_cycle && !pc_load; endproperty
    a_zero: assert property (p_zero) else $error("zero word acted");
    property p_lone; instr_valid && instr_word[15:12] == 4'hF
        |=> op_valid && !file_wr_en; endproperty
    a_lone: assert property (p_lone) else $error("lone word wrote");
    property p_wdt; watchdog_restart_op |-> $past(instr_word) == 16'h0004;
    endproperty
    a_wdt: assert property (p_wdt) else $error("bad restart");
    property p_daw; decimal_adjust_op |-> $past(instr_word) == 16'h0007;
    endproperty
    a_daw: assert property (p_daw) else $error("bad adjust");
    property p_rst; soft_reset |-> $past(instr_word) == 16'h00FF; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_push; stack_push |-> $past(instr_word) == 16'h0005 ||
        $past(instr_word[15:11]) == 5'h1B || $past(instr_word[15:12]) == 4'hF;
    endproperty
    a_push: assert property (p_push) else $error("bad push");
    property p_wr; file_wr_en |->
        $past(instr_word[15:12]) inside {4'h7, 4'h8, 4'h9}; endproperty
    a_wr: assert property (p_wr) else $error("bad file write");
endmodule // bcd_decoder_chk
bind bcd_decoder bcd_decoder_chk chk_u (.clk, .sys_rst, .instr_valid,
    .instr_word, .op_valid, .nop_cycle, .pc_load, .file_wr_en, .stack_push,
    .watchdog_restart_op, .decimal_adjust_op, .soft_reset);

// ### test_bit_and_control_op_decoder.sv
// Self-checking bench for the bit and control operation decoder
`timescale 1ns/1ps
module test_bit_and_control_op_decoder;
    logic clk = 0, sys_rst = 1, stall = 0, instr_valid, zero_flag = 0;
    logic carry_flag = 0, ovf_flag = 0, neg_flag = 0, kill = 0, sk = 0,
        pend = 0;
    logic [15:0] instr_word, w, r;
    logic [4:0]  op_class;
    logic [2:0]  bit_sel;
    logic [7:0]  file_addr;
    logic [20:0] pc_next, pc_target, pn, t;
    logic [7:0]  file_rd_data = 0, file_wr_data, working_register_literal, fd, d, lo;
    logic [3:0]  fl;
    logic op_valid, nop_cycle, file_wr_en, pc_load, stack_push, stack_pop,
        working_register_load, watchdog_restart_op, decimal_adjust_op, soft_reset, v,
        global_irq_enable, nop, pl, pu, po, wr, wd, da, rs, ie, wl, cl, sh,
        ss, shadow_save, shadow_restore, timeout_flag_set, access_bank,
        powerdown_flag_set, peripheral_irq_enable;
    logic [15:0] sp [8] = '{16'h0000, 16'h0004, 16'h0005, 16'h0006,
        16'h0007, 16'h00FF, 16'h0011, 16'h0C5A};
    integer error_cnt = 0, n_tests = 0, seed = 22942, i;
    bcd_prog_mem pm_u (.clk, .sys_rst, .stall, .instr_valid, .instr_word,
        .pc_next);
    bcd_decoder dut_u (.*);
    task check(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        #40000 error_cnt++;
        summarize;
    end
    // Random program with the unhandled groups swapped for control words
    initial begin
        for (i = 0; i < 4096; i++) begin
            r = $random(seed);
            if (r[15:12] < 7 || r[15:12] == 12)
                r = sp[r[2:0]] ^ (r[3:0] == 4'hE); // Both return forms
            pm_u.mem[i] = r;
        end
        repeat (3) @(posedge clk);
        #1 sys_rst = 0;
        repeat (3000) begin
            @(posedge clk);
            #1 {stall, file_rd_data, neg_flag, ovf_flag, carry_flag,
                zero_flag} = $random(seed);
        end
        summarize;
    end
    // Capture what the decoder took at each edge
    always @(posedge clk) begin
        v <= instr_valid && !sys_rst;
        w <= instr_word;
        pn <= pc_next;
        fd <= file_rd_data;
        fl <= {neg_flag, ovf_flag, carry_flag, zero_flag};
    end
    // Reference model, compared once the registered results settle
    always @(negedge clk) if (!sys_rst) begin
        {nop, pl, pu, po, wr, wd, da, rs, ie, wl, ss} = 0;
        d = fd;
        t = 0;
        if (v && kill) begin
            nop = 1;
            kill = sk && (w[15:9] == 7'h76 || w[15:8] == 8'hEF);
            sk = 0;
        end else if (v && pend) begin
            pend = 0;
            nop = w[15:12] != 4'hF;
            {pl, kill, pu} = {!nop, !nop, !nop && cl};
            ss = pu && sh;
            t = {w[11:0], lo, 1'b0};
        end else if (v) case (w[15:12])
            4'h9: {wr, d[w[11:9]]} = 2'h2;
            4'h8: {wr, d[w[11:9]]} = 2'h3;
            4'h7: {wr, d[w[11:9]]} = {1'b1, !fd[w[11:9]]};
            4'hA, 4'hB: {kill, sk} = {2{fd[w[11:9]] ^ w[12]}};
            4'hD: begin
                {pl, kill, pu} = {2'h3, w[11]};
                t = pn + 2 * int'($signed(w[10:0]));
            end
            4'hE: if (!w[11]) begin
                pl = fl[w[10:9]] ^ w[8];
                kill = pl;
                t = pn + 2 * int'($signed(w[7:0]));
            end else if (w[11:9] == 3'h6 || w[11:8] == 4'hF)
                {pend, lo, cl, sh} = {1'b1, w[7:0], !w[9], w[8]};
            4'hF: nop = 1;
            4'h0: case (w)
                16'h0000: nop = 1;
                16'h0004: wd = 1;
                16'h0005: pu = 1;
                16'h0006: po = 1;
                16'h0007: da = 1;
                16'h00FF: rs = 1;
                16'h0010, 16'h0011: {po, pl, ie, kill} = 4'hF;
                default: {po, pl, wl, kill} = {4{w[15:8] == 8'h0C}};
            endcase
        endcase
        check("pulses", {op_valid, nop_cycle, pc_load, stack_push, stack_pop,
            file_wr_en, watchdog_restart_op, decimal_adjust_op, soft_reset,
            global_irq_enable, working_register_load, shadow_save, shadow_restore,
            timeout_flag_set, powerdown_flag_set, peripheral_irq_enable},
            {v, nop, pl, pu, po, wr, wd, da, rs, ie, wl, ss, ie & w[0],
            wd, wd, ie});
        if (v) check("fields", {bit_sel, access_bank, file_addr},
            w[11:0]);
        if (wd || da || rs)
            check("class", op_class, wd ? 5'h0B : da ? 5'h0C : 5'h0F);
        if (pl && !po) check("target", pc_target, t);
        if (wr) check("file data", file_wr_data, d);
        if (wl) check("literal", working_register_literal, w[7:0]);
    end
endmodule // test_bit_and_control_op_decoder
